// ---- core/eeprom_pkg.sv ----
// Purpose: shared constants and types of the serial EEPROM front end
// Assumes: 200 MHz system clock, link pins sampled by that clock
// Notes: bus offsets are byte addresses on a 32-bit Avalon-MM slave
`default_nettype none
package eeprom_pkg;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int WRITE_TIME_MS = 5;
   localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_FREQ_MHZ;
   localparam int TIMER_W = 20;
   localparam int MEM_DEPTH = 256;
   localparam int PAGE_BYTES = 16;
   localparam int BUS_AW = 4;
   localparam logic [BUS_AW-1:0] STATUS_OFS = 4'h0;
   localparam logic [BUS_AW-1:0] CTRL_OFS = 4'h4;
   // bus status and control register fields
   localparam int BS_BUSY_BIT = 0;
   localparam int BS_LATCH_BIT = 1;
   localparam int BS_BP_LSB = 2;
   localparam int BS_PIN_EN_BIT = 4;
   localparam int BS_HW_GUARD_BIT = 5;
   localparam int BS_SELECTED_BIT = 6;
   localparam int BS_PAUSED_BIT = 7;
   localparam int CTRL_POWER_GOOD_BIT = 0;
   localparam logic CTRL_POWER_GOOD_RST = 1'b0;
   // serial status byte fields
   localparam int ST_READY_N_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_BP_LSB = 2;
   localparam int ST_PIN_EN_BIT = 7;
   localparam logic [7:0] ST_BUSY_VALUE = 8'hFF;
   localparam logic [1:0] BP_RST = 2'h0;
   localparam logic PIN_EN_RST = 1'b0;
   // opcode: upper nibble zero, bit 3 ignored, low three bits select
   localparam logic [3:0] OP_HIGH = 4'h0;
   localparam logic [2:0] OP_SET_LATCH = 3'h6;
   localparam logic [2:0] OP_CLEAR_LATCH = 3'h4;
   localparam logic [2:0] OP_STATUS_READ = 3'h5;
   localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
   localparam logic [2:0] OP_ARRAY_READ = 3'h3;
   localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
   // pin order: cs_n, hold_n, wp_n, sck, si
   localparam logic [4:0] PIN_RST = 5'h1C;

   typedef enum logic [2:0] {
      no_cmd, set_write_latch_cmd, clear_write_latch_cmd, status_read_cmd,
      status_write_cmd, array_read_cmd, array_write_cmd
   } cmd_type;

   typedef enum logic [2:0] {
      st_idle, st_opcode, st_addr, st_wdata, st_rdata, st_ignore
   } link_state_type;

   function automatic cmd_type decode_op(input logic [7:0] b);
      cmd_type c;
      c = no_cmd;
      if (b[7:4] == OP_HIGH) begin
         case (b[2:0])
            OP_SET_LATCH: c = set_write_latch_cmd;
            OP_CLEAR_LATCH: c = clear_write_latch_cmd;
            OP_STATUS_READ: c = status_read_cmd;
            OP_STATUS_WRITE: c = status_write_cmd;
            OP_ARRAY_READ: c = array_read_cmd;
            OP_ARRAY_WRITE: c = array_write_cmd;
            default: c = no_cmd;
         endcase
      end
      return c;
   endfunction : decode_op

   function automatic logic is_guarded(input logic [7:0] a, input logic [1:0] bp);
      logic g;
      g = 1'b0;
      case (bp)
         2'h1: g = (a[7:6] == 2'h3);
         2'h2: g = a[7];
         2'h3: g = 1'b1;
         default: g = 1'b0;
      endcase
      return g;
   endfunction : is_guarded
endpackage : eeprom_pkg
`default_nettype wire

// ---- core/mem_if.sv ----
// Purpose: port bundle between the front end and its byte store
// Assumes: one write and one read port, read data registered
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface mem_if;
   logic we;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic re;
   logic [7:0] raddr;
   logic [7:0] rdata;
   modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
   modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : mem_if
`default_nettype wire

// ---- core/byte_mem.sv ----
// Purpose: 256 x 8 storage array
// Assumes: read data valid one clock after re
// Notes: contents undefined until written
`timescale 1ns/10ps
`default_nettype none
module byte_mem (
   input wire logic clk,
   mem_if.store port
);
   import eeprom_pkg::*;
   logic [7:0] cells [MEM_DEPTH];

   always_ff @(posedge clk) begin
      if (port.we) begin
         cells[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (port.re) begin
         port.rdata <= cells[port.raddr];
      end
   end
endmodule : byte_mem
`default_nettype wire

// ---- core/pin_sync.sv ----
// Purpose: two-flop synchronisers for the link pins
// Assumes: each bit is an independent asynchronous level
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_r <= RST_VAL[i];
               q[i] <= RST_VAL[i];
            end else begin
               meta_r <= d[i];
               q[i] <= meta_r;
            end
         end
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

// ---- core/spi_eeprom_slave_front_end.sv ----
// Purpose: serial link front end of a 256-byte serial EEPROM
// Assumes: link pins asynchronous to clk, shift clock far slower than clk
// Notes: software gates power-up and watches state over Avalon-MM
//
// Behaviour
// - sample input on rising shift clock, drive output on falling; modes 0 and 3
// - opcode, address and data move most significant bit first both ways
// - first byte after select falls is the opcode, decoded when defined
// - select high and not writing: standby with output in high impedance
// - protect pin low with pin enable set freezes guard bits and enable
// - pause pin low suspends sequence, ignoring clock and input; resume after
// - pause pin held high means the device never suspends
// - ignore instructions until power-up releases, then reset to standby
// - array of 256 bytes in pages of sixteen bytes
// - single byte and page writes up to sixteen bytes, partial pages allowed
// - internal write is self-timed and finishes within five milliseconds
// - opcode encodings with bit three ignored
// - while writing, status bit zero reads one; only status read accepted
// - write latch set only by its command; cleared at power-up and after writes
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_slave_front_end #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [eeprom_pkg::BUS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic so,
   output logic so_oe
);
   import eeprom_pkg::*;

   mem_if mem ();

   logic [4:0] pin_q;
   logic cs_q;
   logic hold_q;
   logic wp_q;
   logic sck_q;
   logic si_q;
   logic sck_prev_r;
   logic cs_prev_r;
   logic sck_rise;
   logic sck_fall;
   logic end_evt;

   link_state_type state_r;
   cmd_type cmd_r;
   cmd_type op_dec;
   logic [2:0] bit_cnt_r;
   logic [6:0] in_sh_r;
   logic [7:0] byte_in;
   logic byte_done;
   logic [7:0] addr_r;

   logic [7:0] out_sh_r;
   logic [2:0] out_cnt_r;
   logic oe_r;
   logic load_r;
   logic rd_req;
   logic reload;
   logic [7:0] status_byte;

   logic [7:0] page_buf_r [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_mask_r;
   logic [3:0] page_base_r;
   logic [3:0] col_r;
   logic got_byte_r;
   logic [7:0] status_pend_r;

   logic latch_r;
   logic [1:0] bp_r;
   logic pin_en_r;
   logic busy_r;
   logic wr_status_r;
   logic [TIMER_W-1:0] timer_r;
   logic hw_guard;

   logic ack_r;
   logic power_good_r;

   byte_mem u_mem (
      .clk(clk),
      .port(mem.store)
   );

   pin_sync #(
      .W(5),
      .RST_VAL(PIN_RST)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({cs_n, hold_n, wp_n, sck, si}),
      .q(pin_q)
   );

   assign {cs_q, hold_q, wp_q, sck_q, si_q} = pin_q;

   // edges only count while selected and not paused
   assign sck_rise = sck_q & ~sck_prev_r & ~cs_q & hold_q;
   assign sck_fall = ~sck_q & sck_prev_r & ~cs_q & hold_q;
   assign end_evt = cs_q & ~cs_prev_r;
   assign byte_in = {in_sh_r, si_q};
   assign byte_done = sck_rise & (bit_cnt_r == 3'h7);
   assign op_dec = decode_op(byte_in);
   assign hw_guard = ~wp_q & pin_en_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         sck_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
      end else begin
         sck_prev_r <= sck_q;
         cs_prev_r <= cs_q;
      end
   end

   // serial status byte, all ones while a write runs
   always_comb begin
      status_byte = '0;
      status_byte[ST_LATCH_BIT] = latch_r;
      status_byte[ST_BP_LSB +: 2] = bp_r;
      status_byte[ST_PIN_EN_BIT] = pin_en_r;
      if (busy_r) begin
         status_byte = ST_BUSY_VALUE;
      end
   end

   // link sequencer
   always_ff @(posedge clk) begin
      if (rst || !power_good_r) begin
         state_r <= st_idle;
         cmd_r <= no_cmd;
         bit_cnt_r <= 3'h0;
         in_sh_r <= 7'h00;
         addr_r <= 8'h00;
      end else if (cs_q) begin
         state_r <= st_idle;
         bit_cnt_r <= 3'h0;
      end else begin
         if (state_r == st_idle) begin
            state_r <= st_opcode;
            cmd_r <= no_cmd;
         end
         if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_sh_r <= {in_sh_r[5:0], si_q};
         end
         if (byte_done) begin
            case (state_r)
               st_opcode: begin
                  cmd_r <= op_dec;
                  if (busy_r && op_dec != status_read_cmd) begin
                     state_r <= st_ignore;
                  end else begin
                     case (op_dec)
                        status_read_cmd: state_r <= st_rdata;
                        status_write_cmd: state_r <= st_wdata;
                        array_read_cmd: state_r <= st_addr;
                        array_write_cmd: state_r <= st_addr;
                        default: state_r <= st_ignore;
                     endcase
                  end
               end
               st_addr: begin
                  addr_r <= byte_in;
                  state_r <= (cmd_r == array_read_cmd) ? st_rdata : st_wdata;
               end
               default: state_r <= state_r;
            endcase
         end
         if (reload && cmd_r == array_read_cmd) begin
            addr_r <= addr_r + 8'h01;  // sequential read wraps at the top
         end
      end
   end

   // array read requests: first byte after the address, next on each byte end
   assign reload = (state_r == st_rdata) && sck_fall && (out_cnt_r == 3'h7);
   always_comb begin
      rd_req = 1'b0;
      mem.raddr = addr_r + 8'h01;
      if (byte_done && state_r == st_addr && cmd_r == array_read_cmd) begin
         rd_req = 1'b1;
         mem.raddr = byte_in;
      end else if (reload && cmd_r == array_read_cmd) begin
         rd_req = 1'b1;
      end
   end
   assign mem.re = rd_req;

   // output shifter
   always_ff @(posedge clk) begin
      if (rst || cs_q || !power_good_r) begin
         oe_r <= 1'b0;
         out_cnt_r <= 3'h0;
         load_r <= 1'b0;
         so <= 1'b0;
      end else begin
         load_r <= rd_req;
         if (byte_done && state_r == st_opcode && op_dec == status_read_cmd) begin
            out_sh_r <= status_byte;
         end else if (load_r) begin
            out_sh_r <= mem.rdata;
         end else if (state_r == st_rdata && sck_fall) begin
            so <= out_sh_r[7];
            oe_r <= 1'b1;
            out_cnt_r <= out_cnt_r + 3'h1;
            out_sh_r <= {out_sh_r[6:0], 1'b0};
            if (out_cnt_r == 3'h7 && cmd_r == status_read_cmd) begin
               out_sh_r <= status_byte;  // status repeats while selected
            end
         end
      end
   end

   // output released while paused or outside the read data phase
   assign so_oe = oe_r & hold_q & (state_r == st_rdata);

   // write data capture into the page buffer
   always_ff @(posedge clk) begin
      if (rst || !power_good_r) begin
         page_mask_r <= '0;
         page_base_r <= 4'h0;
         col_r <= 4'h0;
         got_byte_r <= 1'b0;
         status_pend_r <= 8'h00;
      end else if (!cs_q) begin
         if (state_r == st_idle) begin
            got_byte_r <= 1'b0;
         end
         if (byte_done && state_r == st_addr) begin
            page_base_r <= byte_in[7:4];
            col_r <= byte_in[3:0];
            page_mask_r <= '0;
         end
         if (byte_done && state_r == st_wdata) begin
            got_byte_r <= 1'b1;
            if (cmd_r == status_write_cmd) begin
               status_pend_r <= byte_in;
            end else begin
               page_buf_r[col_r] <= byte_in;
               page_mask_r[col_r] <= 1'b1;
               col_r <= col_r + 4'h1;  // wraps within the page
            end
         end
      end
   end

   // instruction completion and self-timed write engine
   always_ff @(posedge clk) begin
      if (rst) begin
         bp_r <= BP_RST;
         pin_en_r <= PIN_EN_RST;
      end
      if (rst || !power_good_r) begin
         latch_r <= 1'b0;
         busy_r <= 1'b0;
         wr_status_r <= 1'b0;
         timer_r <= '0;
      end else if (busy_r) begin
         timer_r <= timer_r + 1'b1;
         if (timer_r == TIMER_W'(WRITE_CYCLES - 1)) begin
            busy_r <= 1'b0;
            latch_r <= 1'b0;
            if (wr_status_r) begin
               bp_r <= status_pend_r[ST_BP_LSB +: 2];
               pin_en_r <= status_pend_r[ST_PIN_EN_BIT];
            end
         end
      end else if (end_evt && bit_cnt_r == 3'h0) begin
         // only whole bytes complete an instruction
         case (cmd_r)
            set_write_latch_cmd: latch_r <= 1'b1;
            clear_write_latch_cmd: latch_r <= 1'b0;
            status_write_cmd: begin
               if (got_byte_r && latch_r && !hw_guard) begin
                  busy_r <= 1'b1;
                  wr_status_r <= 1'b1;
                  timer_r <= '0;
               end
            end
            array_write_cmd: begin
               if (got_byte_r && latch_r && !is_guarded({page_base_r, 4'h0}, bp_r)) begin
                  busy_r <= 1'b1;
                  wr_status_r <= 1'b0;
                  timer_r <= '0;
               end
            end
            default: busy_r <= 1'b0;
         endcase
      end
   end

   // commit the page during the first sixteen cycles of the write
   always_comb begin
      mem.we = 1'b0;
      mem.waddr = {page_base_r, timer_r[3:0]};
      mem.wdata = page_buf_r[timer_r[3:0]];
      if (busy_r && !wr_status_r && timer_r < TIMER_W'(PAGE_BYTES)) begin
         mem.we = page_mask_r[timer_r[3:0]];
      end
   end

   // Avalon-MM slave: one wait cycle, then the answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         power_good_r <= CTRL_POWER_GOOD_RST;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         if (avs_read && !ack_r) begin
            avs_readdata <= 32'h0000_0000;
            case (avs_address)
               STATUS_OFS: begin
                  avs_readdata[BS_BUSY_BIT] <= busy_r;
                  avs_readdata[BS_LATCH_BIT] <= latch_r;
                  avs_readdata[BS_BP_LSB +: 2] <= bp_r;
                  avs_readdata[BS_PIN_EN_BIT] <= pin_en_r;
                  avs_readdata[BS_HW_GUARD_BIT] <= hw_guard;
                  avs_readdata[BS_SELECTED_BIT] <= ~cs_q;
                  avs_readdata[BS_PAUSED_BIT] <= ~hold_q;
               end
               CTRL_OFS: avs_readdata[CTRL_POWER_GOOD_BIT] <= power_good_r;
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
         if (avs_write && ack_r && avs_address == CTRL_OFS && avs_byteenable[0]) begin
            power_good_r <= avs_writedata[CTRL_POWER_GOOD_BIT];
         end
      end
   end
endmodule : spi_eeprom_slave_front_end
`default_nettype wire

// ---- sim/spi_eeprom_checker.sv ----
// Purpose: port assertions for the EEPROM front end
// Assumes: one clock domain, bound to the top module
// Notes: pg_r mirrors the power-good control bit
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_checker #(
   parameter int unsigned WRITE_CYCLES = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [eeprom_pkg::BUS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so,
   input wire logic so_oe
);
   import eeprom_pkg::*;
   logic pg_r;
   logic st_rd;
   assign st_rd = avs_read && !avs_waitrequest && avs_address == STATUS_OFS;
   always_ff @(posedge clk) begin
      if (rst) begin
         pg_r <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == CTRL_OFS
            && avs_byteenable[0]) begin
         pg_r <= avs_writedata[CTRL_POWER_GOOD_BIT];
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_standby_out_off: assert property (cs_n [*5] |-> !so_oe)
      else $error("output enabled while deselected");
   a_pause_out_off: assert property (!hold_n [*4] |-> !so_oe)
      else $error("output enabled while paused");
   a_gated_link_idle: assert property (!pg_r |-> !so_oe)
      else $error("link active before power good");
   a_gated_no_latch: assert property (st_rd && !pg_r |-> !avs_readdata[BS_LATCH_BIT])
      else $error("latch set before power good");
   a_drive_read_phase: assert property ($rose(so_oe) |-> !sck && !cs_n
      && !$past(cs_n, 20))
      else $error("output enabled outside the data phase");
   a_out_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("serial output moved while shift clock high");
   a_hw_guard_flag: assert property (st_rd && wp_n == $past(wp_n, 6) |->
      avs_readdata[BS_HW_GUARD_BIT] == (avs_readdata[BS_PIN_EN_BIT] & ~wp_n))
      else $error("hardware guard flag wrong");
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != STATUS_OFS
      && avs_address != CTRL_OFS |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   c_output_on: cover property ($rose(so_oe));
   c_pause_in_frame: cover property (!hold_n && !cs_n);
   c_hw_guard: cover property (st_rd && avs_readdata[BS_HW_GUARD_BIT]);
endmodule : spi_eeprom_checker
`default_nettype wire

// ---- sim/spi_master_model.sv ----
// Purpose: SPI master driving the EEPROM link pins
// Assumes: 5 ns clk, shift clock period 25 clk
// Notes: sck set to the mode's idle level before select falls; si inverted once released
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n,
   input wire logic so,
   input wire logic so_oe
);
   localparam int HALF = 12;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // pb is the bit index before whose rising edge a pause is inserted
   task automatic frame(input logic m3, input int n, input logic [7:0] tx [0:17],
         output logic [7:0] rx [0:17], input int pb);
      @(posedge clk);
      sck <= m3;
      tick(4);
      cs_n <= 1'b0;
      tick(HALF);
      for (int i = 0; i < n * 8; i++) begin
         sck <= 1'b0;
         si <= tx[i / 8][7 - i % 8];
         tick(HALF);
         if (i == pb) begin
            hold_n <= 1'b0;
            si <= ~si;
            tick(HALF);
            sck <= 1'b1;
            tick(HALF);
            sck <= 1'b0;
            tick(HALF);
            si <= ~si;
            hold_n <= 1'b1;
            tick(HALF);
         end
         rx[i / 8][7 - i % 8] = so_oe ? so : ~so;
         sck <= 1'b1;
         tick(HALF + 1);
      end
      if (!m3) begin
         sck <= 1'b0;
         tick(HALF);
      end
      cs_n <= 1'b1;
      si <= ~si;
      tick(HALF);
   endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the EEPROM front end
// Assumes: write time shortened to WC clocks
// Notes: bus and link driven from one sequence
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import eeprom_pkg::*;
   localparam int WC = 1000;
   localparam logic [31:0] LATCH = 32'h1 << BS_LATCH_BIT;
   localparam logic [31:0] GUARD = (32'h1 << BS_BP_LSB) | (32'h1 << BS_PIN_EN_BIT);
   localparam logic [31:0] HW = 32'h1 << BS_HW_GUARD_BIT;
   logic clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [BUS_AW-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic cs_n, sck, si, hold_n, wp_n, so, so_oe;
   logic [7:0] tx [0:17];
   logic [7:0] rx [0:17];
   int err_count = 0;
   int n_tests = 0;
   spi_eeprom_slave_front_end #(.WRITE_CYCLES(WC)) spi_eeprom_slave_front_end_inst (
      .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cs_n(cs_n),
      .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
   spi_master_model spi_master_model_inst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so(so), .so_oe(so_oe));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic check8(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check(what, {24'h0, seen}, {24'h0, exp});
   endtask : check8
   task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic cmd(input logic m3, input int n, input int pb, input logic [7:0] b0,
         input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00,
         input logic [7:0] b3 = 8'h00, input logic [7:0] b4 = 8'h00);
      tx = '{0: b0, 1: b1, 2: b2, 3: b3, 4: b4, default: 8'h00};
      spi_master_model_inst.frame(m3, n, tx, rx, pb);
   endtask : cmd
   task automatic wait_ready();
      int k;
      k = 0;
      q = 32'h1;
      while (q[BS_BUSY_BIT] !== 1'b0 && k < 500) begin
         bus(1'b0, STATUS_OFS, 32'h0);
         k++;
      end
      check("write done in time", {31'h0, k < 500}, 32'h1);
   endtask : wait_ready
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      wp_n = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      cmd(1'b0, 1, -1, 8'h06);
      cmd(1'b0, 2, -1, 8'h05);
      check8("gated status", rx[1], 8'hFF);
      bus(1'b0, STATUS_OFS, 32'h0);
      check("status at power-up", q, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      check("unmapped read", q, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b0, CTRL_OFS, 32'h0);
      check("power good", q, 32'h1);
      $display("test power_up done");
      for (int m = 0; m < 2; m++) begin
         cmd(m[0], 3, -1, 8'h05);
         check8("status byte", rx[1], 8'h00);
         check8("status repeat", rx[2], 8'h00);
      end
      cmd(1'b0, 1, -1, 8'h0E);
      bus(1'b0, STATUS_OFS, 32'h0);
      check("latch set", q, LATCH);
      cmd(1'b1, 2, -1, 8'h0D);
      check8("serial latch", rx[1], 8'h1 << ST_LATCH_BIT);
      cmd(1'b0, 1, -1, 8'h04);
      bus(1'b0, STATUS_OFS, 32'h0);
      check("latch cleared", q, 32'h0);
      $display("test latch done");
      cmd(1'b0, 1, -1, 8'h06);
      cmd(1'b1, 5, -1, 8'h02, 8'h1E, 8'hAA, 8'h55, 8'hC3);
      cmd(1'b0, 2, -1, 8'h05);
      check8("busy status", rx[1], ST_BUSY_VALUE);
      cmd(1'b0, 3, -1, 8'h03, 8'h1E);
      check8("read refused busy", rx[2], 8'hFF);
      wait_ready();
      check("latch after write", q, 32'h0);
      cmd(1'b0, 3, -1, 8'h02, 8'h10, 8'h00);
      cmd(1'b0, 4, -1, 8'h03, 8'h1E);
      check8("array byte 1E", rx[2], 8'hAA);
      check8("array byte 1F", rx[3], 8'h55);
      cmd(1'b1, 3, 20, 8'h03, 8'h10);
      check8("page wrap byte", rx[2], 8'hC3);
      $display("test array done");
      cmd(1'b0, 1, -1, 8'h06);
      cmd(1'b0, 2, -1, 8'h01, 8'h84);
      wait_ready();
      check("guard bits", q, GUARD);
      wp_n <= 1'b0;
      cmd(1'b0, 1, -1, 8'h06);
      cmd(1'b0, 2, -1, 8'h01, 8'h00);
      bus(1'b0, STATUS_OFS, 32'h0);
      check("hw guard refusal", q, GUARD | HW | LATCH);
      wp_n <= 1'b1;
      cmd(1'b0, 3, -1, 8'h02, 8'hF0, 8'h5A);
      bus(1'b0, STATUS_OFS, 32'h0);
      check("guarded page refusal", q, GUARD | LATCH);
      $display("test guard done");
      test_done();
   end
endmodule : tb_top
bind spi_eeprom_slave_front_end spi_eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES))
   spi_eeprom_checker_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cs_n(cs_n), .sck(sck), .si(si),
   .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
`default_nettype wire
